// >>> logic/dbg_defs.svh
// constants for the halt-debug program counter tracker and scan chain
//==================================================================
`ifndef DBG_DEFS_SVH
`define DBG_DEFS_SVH

//==================================================================
// program counter advances, in word addresses
`define DBG_ENTRY_ADV_FULL 32'h0000_0004
`define DBG_ENTRY_ADV_SHORT 32'h0000_0003
`define DBG_SYS_ADV 32'h0000_0003
`define DBG_STEP_ADV 32'h0000_0001

//==================================================================
// exception vectors, plain defaults
`define DBG_PREFETCH_VECTOR 32'h0000_000C
`define DBG_DATA_VECTOR 32'h0000_0010

//==================================================================
// boundary scan chain layout, cell n sits at bit n-1
`define DBG_CHAIN_LEN 113
`define DBG_CELL_DATA_LO 0
`define DBG_CELL_CTRL_LO 32
`define DBG_CTRL_BITS 34
`define DBG_CELL_ADDR_LO 66
`define DBG_CELL_DEBUG_LO 98
`define DBG_DEBUG_BITS 15

`endif

// >>> logic/dbg_pkg.sv
// types shared by the halt-debug tracker
package dbg_pkg;
   typedef enum logic [2:0] {
      MODE_USER, MODE_IRQ, MODE_FIQ, MODE_ABORT, MODE_SUPERVISOR
   } cpu_mode_e;

   typedef enum logic [1:0] {
      CAUSE_NONE, CAUSE_NORMAL, CAUSE_SHORT
   } entry_cause_e;

   typedef struct packed {
      logic breakpoint;
      logic watchpoint;
      logic debug_request_input;
      logic prefetch_abort;
      logic data_abort;
      logic irq;
      logic fast_interrupt;
   } core_event_s;

   typedef struct packed {
      logic valid;
      logic speed_select_bit;
      logic is_branch;
      logic [31:0] word_offset;
   } debug_step_s;

   typedef struct packed {
      logic debug_enable_input;
      logic coproc_a;
      logic coproc_b;
      logic bus_enable;
      logic external_condition_input_zero;
      logic external_condition_input_one;
      logic breakpoint_input;
      logic range_match_output_zero;
      logic range_match_output_one;
      logic enable_out_one;
      logic comm_transmit_flag;
      logic comm_receive_flag;
      logic internal_debug_request_output;
   } debug_pins_s;
endpackage : dbg_pkg

// >>> logic/scan_chain.sv
// parallel-capture serial boundary scan register
`timescale 1ns/1ps
module scan_chain #(
   parameter int LEN = 113
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic capture,
   input wire logic shift,
   input wire logic scan_in,
   input wire logic [LEN-1:0] cells,
   output logic scan_out
);
   logic [LEN-1:0] chain;

   //==================================================================
   // capture wins over shift; cell 1 leaves first
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         chain <= '0;
      end else if (capture) begin
         chain <= cells;
      end else if (shift) begin
         chain <= {scan_in, chain[LEN-1:1]};
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         scan_out <= 1'b0;
      end else if (shift) begin
         scan_out <= chain[0];
      end
   end
endmodule : scan_chain

// >>> logic/debug_state_pc_tracking.sv
// halt-debug entry, program counter tracking and bus-side scan chain
`timescale 1ns/1ps
`include "dbg_defs.svh"
module debug_state_pc_tracking
   import dbg_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic instr_done,
   input wire core_event_s events,
   input wire logic [31:0] core_pc,
   input wire logic vector_fetched,
   input wire debug_step_s step,
   input wire logic sys_done,
   input wire logic sys_abort,
   input wire logic monitor_mode_enable,
   input wire logic [31:0] data_bus,
   input wire logic [33:0] bus_control,
   input wire logic [31:0] address_bus,
   input wire debug_pins_s pins,
   input wire logic scan_capture,
   input wire logic scan_shift,
   input wire logic scan_in,
   output logic debug_acknowledge_output,
   output logic [31:0] pc,
   output cpu_mode_e mode,
   output entry_cause_e entry_cause,
   output logic irq_masked,
   output logic fiq_masked,
   output logic irq_remembered,
   output logic abort_remembered,
   output logic scan_out
);
   typedef enum logic [1:0] {
      ST_RUN, ST_VECTOR_WAIT, ST_DEBUG, ST_SYS_ACCESS
   } dbg_state_e;

   dbg_state_e state;
   logic watch_exc;
   logic enter_now;
   logic [31:0] entry_adv;
   logic [`DBG_CHAIN_LEN-1:0] cells;
   logic [31:0] addr_rev;

   //==================================================================
   // entry decode at an instruction boundary
   assign watch_exc = events.watchpoint &
      (events.irq | events.fast_interrupt);
   always_comb begin
      enter_now = 1'b0;
      entry_adv = `DBG_ENTRY_ADV_FULL;
      if (instr_done && pins.debug_enable_input && !events.prefetch_abort
          && !(events.watchpoint && events.data_abort)) begin
         if (watch_exc) begin
            enter_now = 1'b1;
            entry_adv = `DBG_ENTRY_ADV_SHORT;
         end else if (events.breakpoint || events.watchpoint) begin
            enter_now = 1'b1;
         end else if (events.debug_request_input) begin
            enter_now = 1'b1;
            entry_adv = `DBG_ENTRY_ADV_SHORT;
         end
      end
   end

   //==================================================================
   // state sequencing
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_RUN;
      end else begin
         unique case (state)
            ST_RUN: begin
               if (instr_done && pins.debug_enable_input &&
                   events.watchpoint && events.data_abort &&
                   !events.prefetch_abort) begin
                  state <= ST_VECTOR_WAIT;
               end else if (enter_now) begin
                  state <= ST_DEBUG;
               end
            end
            ST_VECTOR_WAIT: begin
               if (vector_fetched) begin
                  state <= ST_DEBUG;
               end
            end
            ST_DEBUG: begin
               if (step.valid && step.is_branch) begin
                  state <= ST_RUN;
               end else if (step.valid && step.speed_select_bit) begin
                  state <= ST_SYS_ACCESS;
               end
            end
            ST_SYS_ACCESS: begin
               if (sys_done) begin
                  state <= ST_DEBUG;
               end
            end
         endcase
      end
   end

   //==================================================================
   // program counter: follows the core while running
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pc <= 32'h0000_0000;
      end else begin
         unique case (state)
            ST_RUN: begin
               if (instr_done && events.prefetch_abort) begin
                  pc <= `DBG_PREFETCH_VECTOR;
               end else if (instr_done && pins.debug_enable_input &&
                            events.watchpoint && events.data_abort) begin
                  pc <= `DBG_DATA_VECTOR;
               end else if (enter_now) begin
                  pc <= core_pc + (entry_adv << 2);
               end else begin
                  pc <= core_pc;
               end
            end
            ST_VECTOR_WAIT: begin
               if (vector_fetched) begin
                  pc <= pc + (`DBG_ENTRY_ADV_SHORT << 2);
               end
            end
            ST_DEBUG: begin
               if (step.valid && step.is_branch) begin
                  // branch counts itself as one debug-speed step
                  pc <= pc + (`DBG_STEP_ADV << 2) + (step.word_offset << 2);
               end else if (step.valid && !step.speed_select_bit) begin
                  pc <= pc + (`DBG_STEP_ADV << 2);
               end
            end
            ST_SYS_ACCESS: begin
               if (sys_done) begin
                  pc <= pc + (`DBG_SYS_ADV << 2);
               end
            end
         endcase
      end
   end

   //==================================================================
   // processor mode
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mode <= MODE_SUPERVISOR;
      end else if (state == ST_RUN && instr_done) begin
         if (events.prefetch_abort) begin
            mode <= MODE_ABORT;
         end else if (pins.debug_enable_input && events.watchpoint &&
                      events.data_abort) begin
            mode <= MODE_ABORT;
         end else if (enter_now && events.fast_interrupt) begin
            mode <= MODE_FIQ;
         end else if (enter_now && events.irq) begin
            mode <= MODE_IRQ;
         end
      end else if (state == ST_SYS_ACCESS && sys_done && sys_abort) begin
         mode <= MODE_ABORT;
      end
   end

   //==================================================================
   // entry cause and remembered exceptions, cleared on return
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         entry_cause <= CAUSE_NONE;
      end else if (state == ST_RUN && enter_now) begin
         entry_cause <= (entry_adv == `DBG_ENTRY_ADV_SHORT) ?
            CAUSE_SHORT : CAUSE_NORMAL;
      end else if (state == ST_VECTOR_WAIT && vector_fetched) begin
         entry_cause <= CAUSE_SHORT;
      end else if (state == ST_DEBUG && step.valid && step.is_branch) begin
         entry_cause <= CAUSE_NONE;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irq_remembered <= 1'b0;
      end else if (state == ST_RUN && enter_now &&
                   (events.irq || events.fast_interrupt)) begin
         irq_remembered <= 1'b1;
      end else if (state == ST_DEBUG && step.valid && step.is_branch) begin
         irq_remembered <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         abort_remembered <= 1'b0;
      end else if ((state == ST_RUN && instr_done && events.watchpoint &&
                    events.data_abort && pins.debug_enable_input) ||
                   (state == ST_SYS_ACCESS && sys_done && sys_abort)) begin
         abort_remembered <= 1'b1;
      end else if (state == ST_DEBUG && step.valid && step.is_branch) begin
         abort_remembered <= 1'b0;
      end
   end

   //==================================================================
   // acknowledge drops during a system-speed access
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         debug_acknowledge_output <= 1'b0;
         irq_masked <= 1'b0;
         fiq_masked <= 1'b0;
      end else begin
         debug_acknowledge_output <= (state == ST_DEBUG);
         // abort mode masks irq in monitor mode until mode leaves MODE_ABORT
         irq_masked <= (state == ST_DEBUG) || (state == ST_SYS_ACCESS) ||
            (monitor_mode_enable && mode == MODE_ABORT);
         fiq_masked <= !monitor_mode_enable &&
            ((state == ST_DEBUG) || (state == ST_SYS_ACCESS));
      end
   end

   //==================================================================
   // boundary scan cell assembly
   always_comb begin
      for (int i = 0; i < 32; i++) begin
         addr_rev[i] = address_bus[31-i];
      end
   end

   assign cells = {
      pins.internal_debug_request_output, pins.comm_receive_flag,
      pins.comm_transmit_flag, pins.enable_out_one,
      pins.range_match_output_one, pins.range_match_output_zero,
      debug_acknowledge_output, pins.breakpoint_input,
      pins.external_condition_input_one,
      pins.external_condition_input_zero, pins.bus_enable,
      pins.coproc_b, pins.coproc_a, pins.debug_enable_input,
      events.debug_request_input,
      addr_rev, bus_control, data_bus};

   scan_chain #(
      .LEN(`DBG_CHAIN_LEN)
   ) u_chain (
      .clock(clock),
      .rst_n(rst_n),
      .capture(scan_capture),
      .shift(scan_shift),
      .scan_in(scan_in),
      .cells(cells),
      .scan_out(scan_out)
   );
endmodule : debug_state_pc_tracking

// >>> tb/dbg_host_model.sv
// host debugger model issuing scanned steps
`timescale 1ns/1ps
module dbg_host_model
   import dbg_pkg::*;
(
   input wire logic clock,
   input wire logic start,
   input wire logic [1:0] nd,
   input wire logic [1:0] ns,
   input wire logic short_c,
   input wire logic abort_sys,
   output debug_step_s step,
   output logic sys_done,
   output logic sys_abort,
   output logic busy
);
   int n;
   logic [31:0] base;
   task send(input logic sp, br, input logic [31:0] off);
      @(posedge clock);
      step <= '{1'b1, sp, br, off};
      @(posedge clock);
      step <= '0;
   endtask : send
   //==========
   // step sequencer, one process owns every output
   initial begin
      step = '0;
      sys_done = 1'b0;
      sys_abort = 1'b0;
      busy = 1'b0;
      forever begin
         @(posedge clock);
         if (start) begin
            busy <= 1'b1;
            n = (nd < 2) ? 2 : nd;
            repeat (ns) begin
               send(1'b1, 1'b0, 32'h0);
               repeat (3) @(posedge clock);
               sys_done <= 1'b1;
               sys_abort <= abort_sys;
               @(posedge clock);
               sys_done <= 1'b0;
               sys_abort <= 1'b0;
               // let the core settle back before the next step
               repeat (2) @(posedge clock);
            end
            repeat (n) send(1'b0, 1'b0, 32'h0);
            base = short_c ? 32'h3 : 32'h4;
            // branch only; a pc subtract would land the same
            send(1'b0, 1'b1, 32'h0 - (base + n + 1 + 3 * ns));
            busy <= 1'b0;
         end
      end
   end
endmodule : dbg_host_model

// >>> tb/dbg_checker.sv
// port assertions for the halt-debug tracker
`timescale 1ns/1ps
`include "dbg_defs.svh"
module dbg_checker
   import dbg_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic instr_done,
   input wire core_event_s events,
   input wire logic [31:0] core_pc,
   input wire logic vector_fetched,
   input wire debug_step_s step,
   input wire logic sys_done,
   input wire logic sys_abort,
   input wire logic monitor_mode_enable,
   input wire debug_pins_s pins,
   input wire logic debug_acknowledge_output,
   input wire logic [31:0] pc,
   input wire cpu_mode_e mode,
   input wire entry_cause_e entry_cause,
   input wire logic irq_masked,
   input wire logic fiq_masked,
   input wire logic abort_remembered,
   input wire logic irq_remembered
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic run;
   assign run = instr_done & pins.debug_enable_input
      & ~debug_acknowledge_output;
   sequence s_acked;
      debug_acknowledge_output && irq_masked;
   endsequence
   //==========
   // entry
   property p_full;
      run && (events == 7'h40 || events == 7'h20) |=>
         pc == $past(core_pc) + 32'h10 ##1 s_acked;
   endproperty
   a_full: assert property (p_full)
      else $error("full entry wrong");
   property p_req;
      run && events.debug_request_input && !events.breakpoint
         && !events.watchpoint && !events.prefetch_abort |=>
         pc == $past(core_pc) + 32'hC
         && entry_cause == CAUSE_SHORT ##1 s_acked;
   endproperty
   a_req: assert property (p_req)
      else $error("request entry wrong");
   property p_irq;
      run && events == 7'h12 |=> mode == MODE_IRQ ##1 irq_remembered;
   endproperty
   a_irq: assert property (p_irq)
      else $error("irq mode wrong");
   property p_pf;
      run && events == 7'h48 |=> !debug_acknowledge_output [*2];
   endproperty
   a_pf: assert property (p_pf)
      else $error("breakpoint not dropped");
   property p_defer;
      run && events == 7'h24 |=> pc == `DBG_DATA_VECTOR
         && mode == MODE_ABORT ##1 !debug_acknowledge_output;
   endproperty
   a_defer: assert property (p_defer)
      else $error("entry not deferred");
   property p_vec;
      vector_fetched |=> pc == $past(pc) + 32'hC
         ##1 debug_acknowledge_output && abort_remembered;
   endproperty
   a_vec: assert property (p_vec)
      else $error("vector entry wrong");
   //==========
   // inside debug
   property p_sys;
      sys_done && !sys_abort |=> pc == $past(pc) + 32'hC;
   endproperty
   a_sys: assert property (p_sys)
      else $error("system access pc wrong");
   property p_sab;
      sys_done && sys_abort |=> mode == MODE_ABORT;
   endproperty
   a_sab: assert property (p_sab)
      else $error("no abort mode");
   property p_step;
      step.valid && !step.speed_select_bit && !step.is_branch
         && debug_acknowledge_output |=> pc == $past(pc) + 32'h4;
   endproperty
   a_step: assert property (p_step)
      else $error("debug step pc wrong");
   property p_fiq;
      debug_acknowledge_output && monitor_mode_enable |-> !fiq_masked;
   endproperty
   a_fiq: assert property (p_fiq)
      else $error("fiq masked in monitor");
endmodule : dbg_checker
bind debug_state_pc_tracking dbg_checker dbg_checker_inst (.clock,
   .rst_n, .instr_done, .events, .core_pc, .vector_fetched, .step,
   .sys_done, .sys_abort, .monitor_mode_enable, .pins, .pc, .mode,
   .debug_acknowledge_output, .entry_cause, .irq_masked, .fiq_masked,
   .abort_remembered, .irq_remembered);

// >>> tb/tb_debug_state_pc_tracking.sv
// self-checking bench for the halt-debug tracker
`timescale 1ns/1ps
`include "dbg_defs.svh"
module tb_debug_state_pc_tracking;
   import dbg_pkg::*;
   logic clock, rst_n, instr_done, vector_fetched, monitor_mode_enable;
   logic scan_capture, scan_shift, scan_in, scan_out, start, short_c;
   logic sys_done, sys_abort, debug_acknowledge_output, busy, abort_sys;
   logic irq_masked, fiq_masked, irq_remembered, abort_remembered;
   logic [31:0] core_pc, data_bus, address_bus, pc;
   logic [33:0] bus_control;
   logic [1:0] nd, ns;
   core_event_s events;
   debug_step_s step;
   debug_pins_s pins;
   cpu_mode_e mode;
   entry_cause_e entry_cause;
   int fail_count, num_checks;
   debug_state_pc_tracking debug_state_pc_tracking_inst (.clock, .rst_n,
      .instr_done, .events, .core_pc, .vector_fetched, .step, .sys_done,
      .sys_abort, .monitor_mode_enable, .data_bus, .bus_control,
      .address_bus, .pins, .scan_capture, .scan_shift, .scan_in,
      .debug_acknowledge_output, .pc, .mode, .entry_cause, .irq_masked,
      .fiq_masked, .irq_remembered, .abort_remembered, .scan_out);
   dbg_host_model dbg_host_model_inst (.clock, .start, .nd, .ns,
      .short_c, .abort_sys, .step, .sys_done, .sys_abort, .busy);
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   //==========
   // shared tasks
   task check(input logic [31:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask : check
   task report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop
   task tick;
      @(posedge clock);
      #1;
   endtask : tick
   task enter(input logic [6:0] ev, input logic [31:0] at);
      @(posedge clock);
      instr_done <= 1'b1;
      events <= ev;
      core_pc <= at;
      @(posedge clock);
      instr_done <= 1'b0;
      events <= '0;
      #1;
   endtask : enter
   task host(input logic [1:0] d, s, input logic sh, ab);
      @(posedge clock);
      {nd, ns, short_c, abort_sys, start} <= {d, s, sh, ab, 1'b1};
      @(posedge clock);
      start <= 1'b0;
      repeat (300) begin
         tick;
         if (busy !== 1'b1) break;
      end
      // returns on the branch cycle, before pc follows core_pc again
      check(busy, 1'b0);
   endtask : host
   //==========
   // scenarios
   task t_break;
      enter(7'h40, 32'h400);
      check(pc, 32'h410);
      check(entry_cause, CAUSE_NORMAL);
      tick;
      check(irq_masked, 1'b1);
      host(2'h2, 2'h1, 1'b0, 1'b0);
      check(pc, 32'h400);
      tick;
      check(debug_acknowledge_output, 1'b0);
      $display("breakpoint test done");
   endtask : t_break
   task t_request;
      monitor_mode_enable <= 1'b1;
      enter(7'h12, 32'h500);
      check(pc, 32'h50C);
      check(mode, MODE_IRQ);
      tick;
      check({irq_remembered, irq_masked, fiq_masked}, 3'h6);
      host(2'h2, 2'h0, 1'b1, 1'b0);
      check(pc, 32'h500);
      monitor_mode_enable <= 1'b0;
      enter(7'h48, 32'h600);
      tick;
      check(debug_acknowledge_output, 1'b0);
      $display("request test done");
   endtask : t_request
   task t_watch_abort;
      enter(7'h24, 32'h700);
      check(pc, `DBG_DATA_VECTOR);
      check(mode, MODE_ABORT);
      tick;
      check(debug_acknowledge_output, 1'b0);
      vector_fetched <= 1'b1;
      tick;
      vector_fetched <= 1'b0;
      check(pc, `DBG_DATA_VECTOR + 32'hC);
      tick;
      check({debug_acknowledge_output, abort_remembered}, 2'h3);
      host(2'h2, 2'h0, 1'b1, 1'b0);
      check(pc, `DBG_DATA_VECTOR);
      enter(7'h22, 32'h800);
      check(pc, 32'h80C);
      check(mode, MODE_IRQ);
      check(entry_cause, CAUSE_SHORT);
      host(2'h2, 2'h1, 1'b1, 1'b1);
      check(pc, 32'h800);
      check(mode, MODE_ABORT);
      tick;
      check(debug_acknowledge_output, 1'b0);
      $display("abort test done");
   endtask : t_watch_abort
   task t_scan;
      logic [127:0] got, exp;
      exp = {15'h0, address_bus, bus_control, data_bus};
      for (int i = 0; i < 32; i++) exp[66 + i] = address_bus[31 - i];
      for (int i = 0; i < 7; i++) exp[99 + i] = pins[12 - i];
      for (int i = 0; i < 6; i++) exp[107 + i] = pins[5 - i];
      exp[98] = 1'b0;
      exp[106] = 1'b0;
      got = '0;
      scan_capture <= 1'b1;
      tick;
      scan_capture <= 1'b0;
      scan_shift <= 1'b1;
      for (int i = 0; i < 113; i++) begin
         tick;
         got[i] = scan_out;
      end
      scan_shift <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         check(got[i*32+:32], exp[i*32+:32]);
      end
      $display("scan test done");
   endtask : t_scan
   //==========
   // main sequence
   initial begin
      {rst_n, instr_done, vector_fetched, monitor_mode_enable} = 4'h0;
      {scan_capture, scan_shift, scan_in, start, short_c} = 5'h0;
      {nd, ns, abort_sys, events, core_pc} = '0;
      data_bus = 32'h1234_5678;
      address_bus = 32'h89AB_CDEF;
      // symmetric pattern, control cell order is not pinned down
      bus_control = 34'h3_0000_0003;
      pins = 13'h1A5B;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      tick;
      check(mode, MODE_SUPERVISOR);
      t_break;
      t_request;
      t_watch_abort;
      t_scan;
      report_and_stop;
   end
   // tests need a few hundred cycles, the limit allows 10000
   initial begin
      #200000;
      fail_count++;
      report_and_stop;
   end
endmodule : tb_debug_state_pc_tracking
